// [core/tpd_regs.vh]
`ifndef TPD_REGS_VH
`define TPD_REGS_VH
// ==========================================
// register addresses
`define TPD_ADDR_DUTY0 8'h05
`define TPD_ADDR_DUTY1 8'h06
`define TPD_ADDR_DUTY2 8'h07
`define TPD_ADDR_MODE 8'h13
// ==========================================
// pin_mode_select fields
`define TPD_MODE_DAC_OUT0 0
`define TPD_MODE_DAC_OUT1 1
`define TPD_MODE_DAC_OUT2 2
`define TPD_MODE_CGP 3
`define TPD_MODE_RESET 4'h0
// ==========================================
// timing
`define TPD_CLK_HZ 200000000
`define TPD_REF_HZ 225000
`define TPD_REF_DIV (`TPD_CLK_HZ / `TPD_REF_HZ)
`define TPD_QUARTER_DIV (`TPD_REF_DIV / 4)
`define TPD_STEPS 256
`endif

// [core/tpd_channel.v]
`timescale 1ns/1ps
// one pwm channel: 8-bit counter on its reference tick, compare with latched duty
module tpd_channel #(
  parameter DIV_W = 10,
  parameter [DIV_W-1:0] QUARTER = 10'd222
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_ce,
  input wire i_ref_tick,
  input wire [DIV_W-1:0] i_phase,
  input wire [7:0] i_duty,
  output reg o_pwm
);
  reg [7:0] count;
  reg [7:0] duty_act;
  wire wrap;

  assign wrap = i_ref_tick && (count == 8'hff);

  // ==========================================
  // counter and period-aligned duty reload
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      count <= 8'h00;
      duty_act <= 8'h00;
      o_pwm <= 1'b0;
    end
    else if (i_ce)
    begin
      if (i_ref_tick)
        count <= count + 8'h01;
      if (wrap)
        duty_act <= i_duty;
      // high while duty exceeds count, plus a quarter reference clock tail
      o_pwm <= (duty_act > count) || ((duty_act == count) && (i_phase < QUARTER));
    end
  end
endmodule

// [core/tpd_pwm_dac.v]
`timescale 1ns/1ps
`include "tpd_regs.vh"
module tpd_pwm_dac #(
  parameter DIV_W = 10
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_ce,
  input wire i_clock_stop,
  input wire [7:0] i_addr,
  input wire i_put,
  input wire i_get,
  input wire [7:0] i_transfer_buffer,
  output reg [7:0] o_transfer_buffer,
  input wire [2:0] i_port_latch,
  output wire o_dac_out0,
  output wire o_dac_out1,
  output wire o_dac_out2,
  output wire o_dac_out0_oe,
  output wire o_dac_out1_oe,
  output wire o_dac_out2_oe,
  output wire o_clockgen_port_select
);
  // counts are worked out as integers, then cut to the divider width on purpose
  localparam integer REF_DIV_I = `TPD_REF_DIV;
  localparam integer QUARTER_I = `TPD_QUARTER_DIV;
  localparam integer PHASE1_I = `TPD_REF_DIV / 3;
  localparam integer PHASE2_I = (`TPD_REF_DIV * 2) / 3;
  localparam [DIV_W-1:0] REF_DIV = REF_DIV_I[DIV_W-1:0];
  localparam [DIV_W-1:0] QUARTER = QUARTER_I[DIV_W-1:0];
  localparam [DIV_W-1:0] PHASE1 = PHASE1_I[DIV_W-1:0];
  localparam [DIV_W-1:0] PHASE2 = PHASE2_I[DIV_W-1:0];

  reg [7:0] dac_out0_duty;
  reg [7:0] dac_out1_duty;
  reg [7:0] dac_out2_duty;
  reg [3:0] pin_mode_select;
  reg [DIV_W-1:0] div;
  wire [2:0] pwm;
  wire [2:0] sel;
  wire [2:0] pin;

  // ==========================================
  // reference divider, one tick per channel at staggered phases
  function [DIV_W-1:0] phase_of;
    input [DIV_W-1:0] d;
    input [DIV_W-1:0] off;
    begin
      phase_of = (d >= off) ? (d - off) : (d + REF_DIV - off);
    end
  endfunction

  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      div <= {DIV_W{1'b0}};
    else if (i_ce)
      div <= (div == REF_DIV - 1'b1) ? {DIV_W{1'b0}} : div + 1'b1;
  end

  // ==========================================
  // register file; reset does not touch duty, so ce reset and halt keep it all
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      pin_mode_select <= `TPD_MODE_RESET;
      o_transfer_buffer <= 8'h00;
    end
    else if (i_clock_stop)
      pin_mode_select <= `TPD_MODE_RESET;
    else if (i_ce)
    begin
      if (i_put && i_addr == `TPD_ADDR_MODE)
        pin_mode_select <= i_transfer_buffer[3:0];
      if (i_get)
      begin
        case (i_addr)
          `TPD_ADDR_DUTY0: o_transfer_buffer <= dac_out0_duty;
          `TPD_ADDR_DUTY1: o_transfer_buffer <= dac_out1_duty;
          `TPD_ADDR_DUTY2: o_transfer_buffer <= dac_out2_duty;
          `TPD_ADDR_MODE: o_transfer_buffer <= {4'h0, pin_mode_select};
          default: o_transfer_buffer <= 8'h00;
        endcase
      end
    end
  end

  // duty registers have no reset value; clock stop leaves them alone
  always @(posedge i_core_clk)
  begin
    if (i_ce && i_put && !i_clock_stop)
    begin
      if (i_addr == `TPD_ADDR_DUTY0)
        dac_out0_duty <= i_transfer_buffer;
      if (i_addr == `TPD_ADDR_DUTY1)
        dac_out1_duty <= i_transfer_buffer;
      if (i_addr == `TPD_ADDR_DUTY2)
        dac_out2_duty <= i_transfer_buffer;
    end
  end

  // ==========================================
  // channels
  tpd_channel #(.DIV_W(DIV_W), .QUARTER(QUARTER)) u_ch0 (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_ref_tick(div == REF_DIV - 1'b1),
    .i_phase(div),
    .i_duty(dac_out0_duty),
    .o_pwm(pwm[0])
  );
  tpd_channel #(.DIV_W(DIV_W), .QUARTER(QUARTER)) u_ch1 (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_ref_tick(div == PHASE1 - 1'b1),
    .i_phase(phase_of(div, PHASE1)),
    .i_duty(dac_out1_duty),
    .o_pwm(pwm[1])
  );
  tpd_channel #(.DIV_W(DIV_W), .QUARTER(QUARTER)) u_ch2 (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_ref_tick(div == PHASE2 - 1'b1),
    .i_phase(phase_of(div, PHASE2)),
    .i_duty(dac_out2_duty),
    .o_pwm(pwm[2])
  );

  // ==========================================
  // pin select; n-channel open drain, driven only while low
  assign sel = pin_mode_select[2:0];
  assign pin = (sel & pwm) | (~sel & i_port_latch);
  assign o_dac_out0 = 1'b0;
  assign o_dac_out1 = 1'b0;
  assign o_dac_out2 = 1'b0;
  assign o_dac_out0_oe = ~pin[0];
  assign o_dac_out1_oe = ~pin[1];
  assign o_dac_out2_oe = ~pin[2];
  assign o_clockgen_port_select = pin_mode_select[`TPD_MODE_CGP];
endmodule

// [dv/tpd_pullup.sv]
`timescale 1ns/1ps
// ==========
// pull-up on the open-drain pins
module tpd_pullup (
  input wire [2:0] i_oe,
  output wire [2:0] o_level
);
  assign o_level = ~i_oe;
endmodule

// [dv/tpd_chk_assertions.sv]
`timescale 1ns/1ps
// ==========
// checker
module tpd_chk (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_ce,
  input wire i_clock_stop,
  input wire [7:0] i_addr,
  input wire i_put,
  input wire i_get,
  input wire [7:0] i_transfer_buffer,
  input wire [7:0] o_transfer_buffer,
  input wire [2:0] i_port_latch,
  input wire o_dac_out0_oe,
  input wire o_dac_out1_oe,
  input wire o_dac_out2_oe,
  input wire o_clockgen_port_select
);
  reg [3:0] ms;
  wire wr = i_ce && i_put && !i_clock_stop;
  // clock stop has priority over a read in the register file
  wire rd = i_ce && i_get && !i_clock_stop;
  wire mapped = (i_addr == 8'h05) || (i_addr == 8'h06) || (i_addr == 8'h07) || (i_addr == 8'h13);
  // shadow of the mode register, cleared by both resets
  always @(posedge i_core_clk)
    if (!i_rst_n || i_clock_stop)
      ms <= 4'h0;
    else if (wr && i_addr == 8'h13)
      ms <= i_transfer_buffer[3:0];
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence put0;
    wr && i_addr == 8'h05;
  endsequence
  sequence get0;
    rd && i_addr == 8'h05;
  endsequence
  AST_OUT0: assert property (!ms[0] |-> o_dac_out0_oe == !i_port_latch[0])
    else $error("pin0 not port");
  AST_OUT1: assert property (!ms[1] |-> o_dac_out1_oe == !i_port_latch[1])
    else $error("pin1 not port");
  AST_OUT2: assert property (!ms[2] |-> o_dac_out2_oe == !i_port_latch[2])
    else $error("pin2 not port");
  AST_CGP: assert property (o_clockgen_port_select == ms[3])
    else $error("cgp flag");
  AST_GETMODE: assert property (rd && i_addr == 8'h13 |=> o_transfer_buffer == {4'h0, $past(ms)})
    else $error("mode read");
  AST_NOMAP: assert property (rd && !mapped |=> o_transfer_buffer == 8'h00)
    else $error("unmapped read");
  AST_HOLD: assert property (!rd |=> $stable(o_transfer_buffer))
    else $error("read data moved");
  AST_DUTY: assert property (put0 ##1 get0 |=> o_transfer_buffer == $past(i_transfer_buffer, 2))
    else $error("duty readback");
  AST_HALT: assert property (!i_ce && !i_clock_stop |=> $stable(o_clockgen_port_select))
    else $error("halt moved mode");
endmodule
bind tpd_pwm_dac tpd_chk i_chk(.*);

// [dv/tpd_pwm_dac_tb_top.sv]
`timescale 1ns/1ps
`include "tpd_regs.vh"
// ==========
// bench
module tpd_pwm_dac_tb_top;
  logic i_core_clk = 0;
  logic i_rst_n = 0;
  logic i_ce = 1;
  logic i_clock_stop = 0;
  logic i_put = 0;
  logic i_get = 0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_transfer_buffer = 8'h00;
  logic [2:0] i_port_latch = 3'h5;
  wire [7:0] o_transfer_buffer;
  wire [2:0] oe;
  wire [2:0] lvl;
  wire [2:0] dout;
  wire cgp;
  int n_mismatch = 0;
  int checks = 0;
  initial forever #2.5 i_core_clk = ~i_core_clk;
  tpd_pwm_dac i_dut(
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_clock_stop(i_clock_stop),
    .i_addr(i_addr),
    .i_put(i_put),
    .i_get(i_get),
    .i_transfer_buffer(i_transfer_buffer),
    .o_transfer_buffer(o_transfer_buffer),
    .i_port_latch(i_port_latch),
    .o_dac_out0(dout[0]),
    .o_dac_out1(dout[1]),
    .o_dac_out2(dout[2]),
    .o_dac_out0_oe(oe[0]),
    .o_dac_out1_oe(oe[1]),
    .o_dac_out2_oe(oe[2]),
    .o_clockgen_port_select(cgp)
  );
  tpd_pullup i_pu(
    .i_oe(oe),
    .o_level(lvl)
  );
  task cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %0t got %h want %h", $time, g, e);
    end
  endtask
  // each access holds its own strobe up and drops the other, so calls run back to back
  // without a strobe being assigned twice in one time step
  task put(input logic [7:0] a, input logic [7:0] d);
    i_get = 0;
    i_addr = a;
    i_transfer_buffer = d;
    i_put = 1;
    @(negedge i_core_clk);
  endtask
  task get(input logic [7:0] a, input logic [7:0] e);
    i_put = 0;
    i_addr = a;
    i_get = 1;
    @(negedge i_core_clk);
    cmp(o_transfer_buffer, e);
  endtask
  task conclude;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge i_core_clk);
    i_rst_n = 1;
    cmp({4'h0, cgp, lvl}, 8'h05);
    cmp({5'h0, dout}, 8'h00);
    put(8'h06, 8'h80);
    put(8'h07, 8'hff);
    put(8'h05, 8'h00);
    get(8'h05, 8'h00);
    get(8'h06, 8'h80);
    get(8'h07, 8'hff);
    get(8'h20, 8'h00);
    put(8'h13, 8'hfa);
    get(8'h13, 8'h0a);
    cmp({5'h0, cgp, lvl[2], lvl[0]}, 8'h07);
    i_ce = 0;
    put(8'h13, 8'h00);
    get(8'h13, 8'h0a);
    i_ce = 1;
    get(8'h13, 8'h0a);
    i_get = 0;
    i_clock_stop = 1;
    @(negedge i_core_clk);
    i_clock_stop = 0;
    get(8'h13, 8'h00);
    get(8'h06, 8'h80);
    i_port_latch = 3'h2;
    #1 cmp({5'h0, lvl}, 8'h02);
    // ==========
    // second reset: channel 0 restarts at count 0 with duty 0, so only the
    // quarter-clock tail is high
    @(negedge i_core_clk);
    i_get = 0;
    i_rst_n = 0;
    repeat (2) @(negedge i_core_clk);
    i_rst_n = 1;
    put(8'h13, 8'h01);
    i_put = 0;
    repeat (`TPD_QUARTER_DIV - 1) @(negedge i_core_clk);
    cmp({5'h0, lvl}, 8'h03);
    @(negedge i_core_clk);
    cmp({5'h0, lvl}, 8'h02);
    cmp({5'h0, dout}, 8'h00);
    conclude;
  end
endmodule
